// ---- hw/option_word_pkg.sv ----
package option_word_pkg;
  localparam logic [13:0] word_addr     = 14'h2007;
  localparam logic [13:0] word_erased   = 14'h3fff;
  localparam int          guard_hi_msb  = 13;
  localparam int          guard_hi_lsb  = 12;
  localparam int          debug_bit     = 11;
  localparam int          unimpl_bit    = 10;
  localparam int          self_wr_bit   = 9;
  localparam int          ee_guard_bit  = 8;
  localparam int          low_volt_bit  = 7;
  localparam int          droop_bit     = 6;
  localparam int          guard_lo_msb  = 5;
  localparam int          guard_lo_lsb  = 4;
  localparam int          pwr_delay_bit = 3;
  localparam int          wdog_bit      = 2;
  localparam int          osc_msb       = 1;
  localparam int          osc_lsb       = 0;
  localparam logic [1:0]  guard_off     = 2'h3;
  localparam logic [1:0]  guard_all     = 2'h0;
  localparam int          clock_mhz     = 125;
  localparam int          powerup_ms    = 72;
  localparam int          powerup_cycles = powerup_ms * 1000 * clock_mhz;
  localparam logic [10:0] settle_count  = 11'h400;

  typedef enum logic [1:0] {
    low_power_crystal_mode  = 2'h0,
    standard_crystal_mode   = 2'h1,
    high_speed_crystal_mode = 2'h2,
    rc_osc_mode             = 2'h3
  } osc_mode_t;

  typedef struct packed {
    logic      code_guard_all;
    logic      code_guard_bad;
    logic      debug_pins_owned;
    logic      flash_self_write_allow;
    logic      eeprom_guard;
    logic      low_volt_program_allow;
    logic      supply_droop_reset_on;
    logic      powerup_delay_on;
    logic      watchdog_on_fuse;
    osc_mode_t osc_mode;
  } options_t;
endpackage

// ---- hw/config_word_option_decoder.sv ----
`timescale 1ns/1ps
module config_word_option_decoder #(
  parameter int powerup_cycles = option_word_pkg::powerup_cycles
) (
  input  wire logic                      clock,
  input  wire logic                      reset,
  input  wire logic                      power_on,
  input  wire logic                      program_mode,
  input  wire logic [13:0]               prog_addr,
  input  wire logic                      prog_write,
  input  wire logic                      prog_read,
  input  wire logic [13:0]               prog_wdata,
  output logic      [13:0]               prog_rdata,
  output logic                           prog_rvalid,
  input  wire logic                      osc_tick,
  input  wire logic                      wdog_rc_tick,
  input  wire logic                      sleeping,
  input  wire logic                      ext_reset,
  input  wire logic                      wdog_timeout,
  input  wire logic                      irq_pending,
  output option_word_pkg::options_t      options,
  output logic                           debug_pin_a_to_debugger,
  output logic                           debug_pin_b_to_debugger,
  output logic                           watchdog_tick,
  output logic                           hold_in_reset,
  output logic                           sleep_exit
);
  typedef enum logic [2:0] {boot_s, idle_s, delay_s, settle_s, run_s} seq_t;

  logic [13:0] word_q, word_d;
  logic [13:0] rdata_q, rdata_d;
  logic        rvalid_q, rvalid_d;
  option_word_pkg::options_t opt_q, opt_d;
  seq_t        seq_q, seq_d;
  logic [31:0] delay_cnt_q, delay_cnt_d;
  logic [10:0] settle_cnt_q, settle_cnt_d;
  logic        hold_q, hold_d;
  logic        wtick_q, wtick_d;
  logic        exit_q, exit_d;
  logic        hit, crystal;

  always_comb begin
    hit = (prog_addr == option_word_pkg::word_addr);
    word_d = word_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    if (program_mode && hit && prog_write) begin
      word_d = prog_wdata;
      word_d[option_word_pkg::unimpl_bit] = 1'b1;
    end
    if (program_mode && hit && prog_read) begin
      rdata_d = word_q;
      rvalid_d = 1'b1;
    end
  end

  always_comb begin
    opt_d = opt_q;
    opt_d.code_guard_all =
      (word_q[option_word_pkg::guard_hi_msb:option_word_pkg::guard_hi_lsb]
       == option_word_pkg::guard_all);
    opt_d.code_guard_bad =
      (word_q[option_word_pkg::guard_hi_msb:option_word_pkg::guard_hi_lsb]
       != word_q[option_word_pkg::guard_lo_msb:option_word_pkg::guard_lo_lsb])
      || ((word_q[option_word_pkg::guard_hi_msb:option_word_pkg::guard_hi_lsb]
           != option_word_pkg::guard_off)
          && !opt_d.code_guard_all);
    opt_d.debug_pins_owned = ~word_q[option_word_pkg::debug_bit];
    opt_d.flash_self_write_allow = word_q[option_word_pkg::self_wr_bit];
    opt_d.eeprom_guard = ~word_q[option_word_pkg::ee_guard_bit];
    opt_d.low_volt_program_allow = word_q[option_word_pkg::low_volt_bit];
    opt_d.supply_droop_reset_on = word_q[option_word_pkg::droop_bit];
    opt_d.watchdog_on_fuse = word_q[option_word_pkg::wdog_bit];
    opt_d.powerup_delay_on = ~word_q[option_word_pkg::pwr_delay_bit]
                             | word_q[option_word_pkg::droop_bit];
    opt_d.osc_mode = option_word_pkg::osc_mode_t'(
      word_q[option_word_pkg::osc_msb:option_word_pkg::osc_lsb]);
  end

  always_comb begin
    exit_d = sleeping & (ext_reset | wdog_timeout | irq_pending);
    wtick_d = opt_q.watchdog_on_fuse & wdog_rc_tick;
  end

  always_comb begin
    crystal = (opt_q.osc_mode != option_word_pkg::rc_osc_mode);
    seq_d = seq_q;
    delay_cnt_d = delay_cnt_q;
    settle_cnt_d = settle_cnt_q;
    hold_d = 1'b1;
    case (seq_q)
      // options decoded from erased word first
      boot_s: begin
        seq_d = idle_s;
      end
      idle_s: begin
        delay_cnt_d = '0;
        settle_cnt_d = '0;
        if (power_on && opt_q.powerup_delay_on) begin
          seq_d = delay_s;
        end else if (power_on && crystal) begin
          seq_d = settle_s;
        end else begin
          seq_d = run_s;
        end
      end
      delay_s: begin
        delay_cnt_d = delay_cnt_q + 32'h1;
        if (delay_cnt_q == 32'(powerup_cycles - 1)) begin
          seq_d = crystal ? settle_s : run_s;
        end
      end
      settle_s: begin
        if (osc_tick) begin
          settle_cnt_d = settle_cnt_q + 11'h1;
        end
        if (settle_cnt_q == option_word_pkg::settle_count) begin
          seq_d = run_s;
        end
      end
      run_s: begin
        hold_d = 1'b0;
        settle_cnt_d = '0;
        // wake restarts settle in crystal modes
        if (exit_q && crystal) begin
          seq_d = settle_s;
          hold_d = 1'b1;
        end
      end
      default: seq_d = idle_s;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      word_q   <= option_word_pkg::word_erased;
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end else begin
      word_q   <= word_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) opt_q <= '0;
    else begin
      opt_q <= opt_d;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      seq_q        <= boot_s;
      delay_cnt_q  <= '0;
      settle_cnt_q <= '0;
      hold_q       <= 1'b1;
    end else begin
      seq_q        <= seq_d;
      delay_cnt_q  <= delay_cnt_d;
      settle_cnt_q <= settle_cnt_d;
      hold_q       <= hold_d;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wtick_q <= 1'b0;
      exit_q  <= 1'b0;
    end else begin
      wtick_q <= wtick_d;
      exit_q  <= exit_d;
    end
  end

  assign prog_rdata              = rdata_q;
  assign prog_rvalid             = rvalid_q;
  assign options                 = opt_q;
  assign debug_pin_a_to_debugger = opt_q.debug_pins_owned;
  assign debug_pin_b_to_debugger = opt_q.debug_pins_owned;
  assign watchdog_tick           = wtick_q;
  assign hold_in_reset           = hold_q;
  assign sleep_exit              = exit_q;
endmodule

// ---- bench/prog_model.sv ----
`timescale 1ns/1ps
module prog_model (
  input  wire logic        clock,
  output logic             program_mode,
  output logic [13:0]      prog_addr,
  output logic             prog_write,
  output logic             prog_read,
  output logic [13:0]      prog_wdata,
  input  wire logic [13:0] prog_rdata,
  input  wire logic        prog_rvalid
);
  initial begin
    program_mode = 1'b0;
    prog_write = 1'b0;
    prog_read = 1'b0;
    prog_addr = 14'h0;
    prog_wdata = 14'h0;
  end
  task automatic access(input logic m, input logic [13:0] a, input logic w,
                        input logic [13:0] d, output logic [13:0] rd,
                        output logic ok);
    @(posedge clock);
    #1 program_mode = m;
    prog_addr = a;
    prog_wdata = {d[5:4], d[11:0]};
    prog_write = w;
    prog_read = !w;
    @(posedge clock);
    #1 ok = prog_rvalid;
    rd = prog_rdata;
    prog_write = 1'b0;
    prog_read = 1'b0;
    prog_addr = ~a;
    prog_wdata = ~prog_wdata;
  endtask
endmodule

// ---- bench/opt_chk.sv ----
`timescale 1ns/1ps
module opt_chk (
  input wire logic                      clock,
  input wire logic                      reset,
  input wire logic                      program_mode,
  input wire logic [13:0]               prog_addr,
  input wire logic                      prog_read,
  input wire logic [13:0]               prog_rdata,
  input wire logic                      prog_rvalid,
  input wire logic                      wdog_rc_tick,
  input wire logic                      sleeping,
  input wire logic                      ext_reset,
  input wire logic                      wdog_timeout,
  input wire logic                      irq_pending,
  input wire option_word_pkg::options_t options,
  input wire logic                      watchdog_tick,
  input wire logic                      sleep_exit
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_read_taken: assert property (
    program_mode && prog_read && prog_addr == option_word_pkg::word_addr
    |=> prog_rvalid) else $error("read not answered");
  a_read_cause: assert property (
    prog_rvalid |-> $past(program_mode && prog_read))
    else $error("stray rvalid");
  a_spare_one: assert property (
    prog_rvalid |-> prog_rdata[10]) else $error("bit 10 low");
  a_droop_delay: assert property (
    options.supply_droop_reset_on |-> options.powerup_delay_on)
    else $error("droop without delay");
  a_wdog_on: assert property (
    options.watchdog_on_fuse && wdog_rc_tick |=> watchdog_tick)
    else $error("tick lost");
  a_wdog_off: assert property (
    !options.watchdog_on_fuse && !$past(options.watchdog_on_fuse)
    |-> !watchdog_tick) else $error("tick while off");
  a_wake_exit: assert property (
    !$past(reset) |-> sleep_exit ==
    $past(sleeping && (ext_reset || wdog_timeout || irq_pending)))
    else $error("wake mismatch");
  a_erased_dec: assert property (
    $fell(reset) |-> ##[1:2] (options.watchdog_on_fuse &&
    options.osc_mode == option_word_pkg::rc_osc_mode)) else $error("default");
endmodule
bind config_word_option_decoder opt_chk chk_u (.*);

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic        clock, reset, power_on, sleeping, irq_pending, mode, wr, rd;
  logic        rvalid, dbg_a, dbg_b, hold, ok, ext_rst, wd_to, wtick, sexit;
  logic [13:0] addr, wdata, rdata, got, adr;
  logic [3:0]  cnt;
  option_word_pkg::options_t opts;
  int          err_total, n_checks, i, k;
  config_word_option_decoder #(.powerup_cycles(20)) dut_u (
    .clock(clock), .reset(reset), .power_on(power_on), .program_mode(mode),
    .prog_addr(addr), .prog_write(wr), .prog_read(rd), .prog_wdata(wdata),
    .prog_rdata(rdata), .prog_rvalid(rvalid), .osc_tick(cnt[0]),
    .wdog_rc_tick(&cnt[1:0]), .sleeping(sleeping), .ext_reset(ext_rst),
    .wdog_timeout(wd_to), .irq_pending(irq_pending), .options(opts),
    .debug_pin_a_to_debugger(dbg_a), .debug_pin_b_to_debugger(dbg_b),
    .watchdog_tick(wtick), .hold_in_reset(hold), .sleep_exit(sexit));
  prog_model pgm_u (.clock(clock), .program_mode(mode), .prog_addr(addr),
    .prog_write(wr), .prog_read(rd), .prog_wdata(wdata),
    .prog_rdata(rdata), .prog_rvalid(rvalid));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) cnt <= #1 cnt + 4'h1;
  task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic count_ticks(input logic [13:0] exp);
    logic [13:0] tk;
    tk = 14'h0;
    repeat (8) begin
      @(posedge clock);
      #1 tk = tk + {13'h0, wtick};
    end
    chk(tk, exp);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_hold(input int lim);
    k = 0;
    while (hold === 1'b1) begin
      @(posedge clock);
      #1 k++;
      if (k > lim) begin
        err_total++;
        print_verdict;
      end
    end
  endtask
  task automatic do_reset(input logic pwr, input int lo, input int hi);
    reset = 1'b1;
    power_on = pwr;
    repeat (6) @(posedge clock);
    #1 reset = 1'b0;
    wait_hold(60);
    chk(14'(k >= lo && k <= hi), 14'h1);
    $display("reset test done");
  endtask
  task automatic t_reg;
    pgm_u.access(1'b1, adr, 1'b0, 14'h0, got, ok);
    chk(got, 14'h3fff);
    pgm_u.access(1'b0, adr, 1'b0, 14'h0, got, ok);
    chk(14'(ok), 14'h0);
    pgm_u.access(1'b0, adr, 1'b1, 14'h0, got, ok);
    pgm_u.access(1'b1, adr ^ 14'h1, 1'b1, 14'h0, got, ok);
    pgm_u.access(1'b1, adr, 1'b0, 14'h0, got, ok);
    chk(got, 14'h3fff);
    pgm_u.access(1'b1, adr, 1'b1, 14'h0, got, ok);
    pgm_u.access(1'b1, adr, 1'b0, 14'h0, got, ok);
    chk(got, 14'h0400);
    chk(14'({dbg_a, dbg_b, opts.code_guard_all}), 14'h7);
    chk(14'({opts.code_guard_bad, opts.eeprom_guard}), 14'h1);
    chk(14'(opts.flash_self_write_allow), 14'h0);
    chk(14'(opts.low_volt_program_allow), 14'h0);
    chk(14'(opts.supply_droop_reset_on), 14'h0);
    chk(14'(opts.watchdog_on_fuse), 14'h0);
    count_ticks(14'h0);
    for (i = 0; i < 4; i++) begin
      pgm_u.access(1'b1, adr, 1'b1, 14'h3fbc | 14'(i), got, ok);
      repeat (2) @(posedge clock);
      #1 chk(14'({opts.osc_mode, opts.powerup_delay_on}), 14'(i * 2));
    end
    count_ticks(14'h2);
    $display("register test done");
  endtask
  task automatic t_wake(input logic [13:0] w, input logic xtal,
                        input logic [2:0] ev);
    pgm_u.access(1'b1, adr, 1'b1, w, got, ok);
    repeat (3) @(posedge clock);
    #1 sleeping = 1'b1;
    {ext_rst, wd_to, irq_pending} = ev;
    @(posedge clock);
    #1 chk(14'(sexit), 14'h1);
    sleeping = 1'b0;
    {ext_rst, wd_to, irq_pending} = 3'h0;
    repeat (3) @(posedge clock);
    #1 chk(14'(hold), 14'(xtal));
    chk(14'(sexit), 14'h0);
    wait_hold(3000);
    if (xtal) chk(14'(k > 2039 && k < 2053), 14'h1);
    $display("wake test done");
  endtask
  initial begin
    {reset, power_on, sleeping, irq_pending, ext_rst, wd_to, cnt} = '0;
    adr = option_word_pkg::word_addr;
    err_total = 0;
    n_checks = 0;
    do_reset(1'b1, 20, 25);
    t_reg;
    t_wake(14'h3ffd, 1'b1, 3'h1);
    t_wake(14'h3fff, 1'b0, 3'h2);
    t_wake(14'h3fff, 1'b0, 3'h4);
    do_reset(1'b0, 1, 4);
    print_verdict;
  end
endmodule
